// ==== inc/smec_pkg.sv ====
package smec_pkg;

  localparam int SMEC_NSM = 4;
  localparam int SMEC_AW = 9;
  localparam int SMEC_DW = 32;
  localparam int SMEC_PCW = 5;
  localparam int SMEC_IMMW = 16;
  localparam int SMEC_SSW = 5;
  localparam int SMEC_SSCW = 3;
  localparam int SMEC_LVLW = 4;

  // Per machine register offsets, machine 0 in the lowest slot
  localparam logic [3:0][8:0] SMEC_CTRL_OFS = {9'h114, 9'h0fc, 9'h0e4, 9'h0cc};
  localparam logic [3:0][8:0] SMEC_IMM_OFS = {9'h120, 9'h108, 9'h0f0, 9'h0d8};

  // Field positions of the execution control word
  localparam int SMEC_STALL_BIT = 31;
  localparam int SMEC_SIDE_EN_BIT = 30;
  localparam int SMEC_SIDE_DIR_BIT = 29;
  localparam int SMEC_PIN_LSB = 24;
  localparam int SMEC_OE_SEL_LSB = 19;
  localparam int SMEC_INLINE_BIT = 18;
  localparam int SMEC_STICKY_BIT = 17;
  localparam int SMEC_TOP_LSB = 12;
  localparam int SMEC_BOT_LSB = 7;
  localparam int SMEC_STAT_SEL_BIT = 4;
  localparam int SMEC_STAT_N_LSB = 0;

  // Reset value and the bits software may store (31 and 6:5 excluded)
  localparam logic [31:0] SMEC_CTRL_RST = 32'h0001f000;
  localparam logic [31:0] SMEC_CTRL_WMASK = 32'h7fffff9f;

  localparam logic [2:0] SMEC_SS_MAX = 3'h5;
  localparam logic [4:0] SMEC_SS_ONES = 5'h1f;

  typedef enum logic {
    SMEC_FORCE_IDLE = 1'b0,
    SMEC_FORCE_HELD = 1'b1
  } smec_force_e;

  typedef enum logic {
    SMEC_SRC_TX = 1'b0,
    SMEC_SRC_RX = 1'b1
  } smec_stat_src_e;

endpackage

// ==== src/smec_exec_ctrl.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ps

// Overview of operation
// - Four control registers, one per machine
// - Bit 31 shows forced instruction still held
// - Side-set enable bit takes field MSB
// - Side-set count includes the enable bit
// - Bit 29 steers side-set to directions
// - Branch pin chosen by absolute GPIO number
// - Selected data bit gates output writes
// - Inline zero with sticky withdraws last write
// - Highest numbered machine wins shared pins
// - Sticky mode re-drives last output every cycle
// - After wrap top, next address is bottom
// - True branch at wrap top beats wrap
// - Wrap bottom field, resets to zero
// - Status yields ones when level below N
// - Field 3:0 holds status comparison level
// - Immediate write executes at once, then resumes
module smec_exec_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [3:0][15:0] forced_instr_o,
  output logic [3:0] forced_valid_o,
  input wire logic [3:0] forced_done_i,
  input wire logic [3:0][4:0] pc_i,
  input wire logic [3:0] branch_taken_i,
  input wire logic [3:0][4:0] branch_target_i,
  output logic [3:0][4:0] pc_next_o,
  input wire logic [31:0] gpio_i,
  output logic [3:0] branch_pin_o,
  input wire logic [3:0][4:0] sideset_field_i,
  input wire logic [3:0][2:0] sideset_bit_count_i,
  output logic [3:0] sideset_valid_o,
  output logic [3:0][4:0] sideset_data_o,
  output logic [3:0] sideset_to_directions_o,
  input wire logic [3:0][3:0] tx_level_i,
  input wire logic [3:0][3:0] rx_level_i,
  output logic [3:0] status_ones_o,
  input wire logic [3:0] out_wr_i,
  input wire logic [3:0] out_dir_i,
  input wire logic [3:0][31:0] out_data_i,
  input wire logic [3:0][31:0] out_mask_i,
  input wire logic [3:0][31:0] out_word_i,
  output logic [31:0] pad_out_o,
  output logic [31:0] pad_dir_o
);

  typedef struct packed {
    logic [3:0][31:0] ctrl;
    smec_pkg::smec_force_e [3:0] force_st;
    logic [3:0][15:0] imm;
    logic [3:0] st_valid;
    logic [3:0] st_dir;
    logic [3:0][31:0] st_data;
    logic [3:0][31:0] st_mask;
    logic [31:0] pad_out;
    logic [31:0] pad_dir;
    logic [31:0] rdata;
  } smec_state_s;

  smec_state_s state_reg;
  smec_state_s state_next;

  logic [3:0] ctrl_hit;
  logic [3:0] imm_hit;
  logic [3:0] new_wr;
  logic [3:0] withdraw;
  logic [3:0] eff_wr;
  logic [3:0] eff_dir;
  logic [3:0][31:0] eff_data;
  logic [3:0][31:0] eff_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [3:0] smec_match(input logic [8:0] addr,
                                            input logic [3:0][8:0] tab);
    logic [3:0] hit;
    hit = 4'h0;
    for (int i = 0; i < smec_pkg::SMEC_NSM; i++) begin
      hit[i] = (addr == tab[i]);
    end
    return hit;
  endfunction

  function automatic logic [4:0] smec_field5(input logic [31:0] word, input int lsb);
    return word[lsb +: 5];
  endfunction

  always_comb begin
    ctrl_hit = smec_match(reg_addr_i, smec_pkg::SMEC_CTRL_OFS);
    imm_hit = smec_match(reg_addr_i, smec_pkg::SMEC_IMM_OFS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output write qualification per machine

  always_comb begin
    for (int n = 0; n < smec_pkg::SMEC_NSM; n++) begin
      logic inline_en;
      logic sticky;
      logic gate;
      inline_en = state_reg.ctrl[n][smec_pkg::SMEC_INLINE_BIT];
      sticky = state_reg.ctrl[n][smec_pkg::SMEC_STICKY_BIT];
      gate = out_word_i[n][smec_field5(state_reg.ctrl[n], smec_pkg::SMEC_OE_SEL_LSB)];
      new_wr[n] = out_wr_i[n] & (~inline_en | gate);
      withdraw[n] = out_wr_i[n] & inline_en & sticky & ~gate;
      if (new_wr[n]) begin
        eff_wr[n] = 1'b1;
        eff_dir[n] = out_dir_i[n];
        eff_data[n] = out_data_i[n];
        eff_mask[n] = out_mask_i[n];
      end else begin
        eff_wr[n] = sticky & state_reg.st_valid[n] & ~withdraw[n];
        eff_dir[n] = state_reg.st_dir[n];
        eff_data[n] = state_reg.st_data[n];
        eff_mask[n] = state_reg.st_mask[n];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h00000000;

    for (int n = 0; n < smec_pkg::SMEC_NSM; n++) begin
      if (reg_wr_i && ctrl_hit[n]) begin
        // reserved and status bits not stored
        state_next.ctrl[n] = reg_wdata_i & smec_pkg::SMEC_CTRL_WMASK;
      end

      unique case (state_reg.force_st[n])
        smec_pkg::SMEC_FORCE_IDLE: begin
          if (reg_wr_i && imm_hit[n]) begin
            state_next.force_st[n] = smec_pkg::SMEC_FORCE_HELD;
          end
        end
        smec_pkg::SMEC_FORCE_HELD: begin
          if (reg_wr_i && imm_hit[n]) begin
            state_next.force_st[n] = smec_pkg::SMEC_FORCE_HELD;
          end else if (forced_done_i[n]) begin
            state_next.force_st[n] = smec_pkg::SMEC_FORCE_IDLE;
          end
        end
      endcase
      if (reg_wr_i && imm_hit[n]) begin
        state_next.imm[n] = reg_wdata_i[smec_pkg::SMEC_IMMW-1:0];
      end

      if (new_wr[n]) begin
        state_next.st_valid[n] = 1'b1;
        state_next.st_dir[n] = out_dir_i[n];
        state_next.st_data[n] = out_data_i[n];
        state_next.st_mask[n] = out_mask_i[n];
      end else if (withdraw[n]) begin
        state_next.st_valid[n] = 1'b0;
      end

      if (reg_rd_i && ctrl_hit[n]) begin
        state_next.rdata = state_reg.ctrl[n];
        state_next.rdata[smec_pkg::SMEC_STALL_BIT] =
          (state_reg.force_st[n] == smec_pkg::SMEC_FORCE_HELD);
      end
    end

    for (int n = 0; n < smec_pkg::SMEC_NSM; n++) begin
      if (eff_wr[n] && !eff_dir[n]) begin
        state_next.pad_out = (state_next.pad_out & ~eff_mask[n]) |
                             (eff_data[n] & eff_mask[n]);
      end
      if (eff_wr[n] && eff_dir[n]) begin
        state_next.pad_dir = (state_next.pad_dir & ~eff_mask[n]) |
                             (eff_data[n] & eff_mask[n]);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
      for (int n = 0; n < smec_pkg::SMEC_NSM; n++) begin
        state_reg.ctrl[n] <= smec_pkg::SMEC_CTRL_RST;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side-set decode and branch pin

  always_comb begin
    for (int n = 0; n < smec_pkg::SMEC_NSM; n++) begin
      logic [2:0] cnt;
      logic [4:0] raw;
      cnt = sideset_bit_count_i[n];
      if (cnt > smec_pkg::SMEC_SS_MAX) begin
        cnt = smec_pkg::SMEC_SS_MAX;
      end
      raw = sideset_field_i[n] >> (smec_pkg::SMEC_SS_MAX - cnt);
      if (state_reg.ctrl[n][smec_pkg::SMEC_SIDE_EN_BIT]) begin
        sideset_valid_o[n] = (cnt != 3'h0) & sideset_field_i[n][smec_pkg::SMEC_SSW-1];
        sideset_data_o[n] = (cnt == 3'h0) ? 5'h00 :
                            raw & ~(smec_pkg::SMEC_SS_ONES << (cnt - 3'h1));
      end else begin
        sideset_valid_o[n] = (cnt != 3'h0);
        sideset_data_o[n] = raw;
      end
      sideset_to_directions_o[n] = state_reg.ctrl[n][smec_pkg::SMEC_SIDE_DIR_BIT];
      branch_pin_o[n] = gpio_i[smec_field5(state_reg.ctrl[n], smec_pkg::SMEC_PIN_LSB)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter step and status compare

  for (genvar g = 0; g < smec_pkg::SMEC_NSM; g++) begin : g_step
    smec_pc_step u_step (
      .pc_i(pc_i[g]),
      .wrap_top_i(state_reg.ctrl[g][smec_pkg::SMEC_TOP_LSB +: smec_pkg::SMEC_PCW]),
      .wrap_bottom_i(state_reg.ctrl[g][smec_pkg::SMEC_BOT_LSB +: smec_pkg::SMEC_PCW]),
      .branch_taken_i(branch_taken_i[g]),
      .branch_target_i(branch_target_i[g]),
      .stat_sel_i(state_reg.ctrl[g][smec_pkg::SMEC_STAT_SEL_BIT]),
      .stat_n_i(state_reg.ctrl[g][smec_pkg::SMEC_STAT_N_LSB +: smec_pkg::SMEC_LVLW]),
      .tx_level_i(tx_level_i[g]),
      .rx_level_i(rx_level_i[g]),
      .pc_next_o(pc_next_o[g]),
      .status_ones_o(status_ones_o[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    reg_rdata_o = state_reg.rdata;
    forced_instr_o = state_reg.imm;
    pad_out_o = state_reg.pad_out;
    pad_dir_o = state_reg.pad_dir;
    for (int n = 0; n < smec_pkg::SMEC_NSM; n++) begin
      forced_valid_o[n] = (state_reg.force_st[n] == smec_pkg::SMEC_FORCE_HELD);
    end
  end

endmodule

// ==== src/smec_pc_step.sv ====
`timescale 1ns/1ps

module smec_pc_step (
  input wire logic [4:0] pc_i,
  input wire logic [4:0] wrap_top_i,
  input wire logic [4:0] wrap_bottom_i,
  input wire logic branch_taken_i,
  input wire logic [4:0] branch_target_i,
  input wire logic stat_sel_i,
  input wire logic [3:0] stat_n_i,
  input wire logic [3:0] tx_level_i,
  input wire logic [3:0] rx_level_i,
  output logic [4:0] pc_next_o,
  output logic status_ones_o
);

  logic [3:0] level;

  always_comb begin
    if (branch_taken_i) begin
      pc_next_o = branch_target_i;
    end else if (pc_i == wrap_top_i) begin
      pc_next_o = wrap_bottom_i;
    end else begin
      pc_next_o = pc_i + 5'h01;
    end
  end

  always_comb begin
    unique case (smec_pkg::smec_stat_src_e'(stat_sel_i))
      smec_pkg::SMEC_SRC_TX: level = tx_level_i;
      smec_pkg::SMEC_SRC_RX: level = rx_level_i;
    endcase
    status_ones_o = (level < stat_n_i);
  end

endmodule

// ==== tb/smec_exec_ctrl_properties.sv ====
`timescale 1ns/1ps

module smec_exec_ctrl_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [3:0] forced_valid_o,
  input wire logic [3:0] forced_done_i
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  sequence imm0_wr_s;
    reg_wr_i && reg_addr_i == 9'h0d8;
  endsequence
  sequence ctrl0_rd_s;
    reg_rd_i && reg_addr_i == 9'h0cc;
  endsequence

  AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  AST_UNMAPPED_ZERO: assert property (
    reg_rd_i && reg_addr_i < 9'h0cc |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RSVD_ZERO: assert property (reg_rdata_o[6:5] == 2'h0)
    else $error("reserved bits not zero");
  AST_FORCE_SET: assert property (imm0_wr_s |=> forced_valid_o[0])
    else $error("forced instruction not held");
  AST_FORCE_HOLD: assert property (
    forced_valid_o[0] && !forced_done_i[0] |=> forced_valid_o[0])
    else $error("forced hold dropped early");
  AST_FORCE_CLR: assert property (
    forced_valid_o[0] && forced_done_i[0] && !(reg_wr_i && reg_addr_i == 9'h0d8)
    |=> !forced_valid_o[0])
    else $error("forced hold not cleared");
  AST_FORCE_CAUSE: assert property (
    !forced_valid_o[0] && !(reg_wr_i && reg_addr_i == 9'h0d8) |=> !forced_valid_o[0])
    else $error("forced hold without write");
  AST_STALL_BIT: assert property (
    ctrl0_rd_s ##0 (forced_valid_o[0] && !forced_done_i[0]) |=> reg_rdata_o[31])
    else $error("stall bit not shown");
  AST_FORCE_RUN: assert property (
    imm0_wr_s ##1 !forced_done_i[0] [*2] |=> forced_valid_o[0])
    else $error("forced hold lost");
endmodule

bind smec_exec_ctrl smec_exec_ctrl_chk i_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .forced_valid_o(forced_valid_o),
  .forced_done_i(forced_done_i)
);

// ==== tb/tb_smec_exec_ctrl.sv ====
`timescale 1ns/1ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_smec_exec_ctrl;
  logic clk = 0, rst = 1, we = 0, re = 0;
  logic [8:0] a = '0;
  logic [31:0] wd = '0, gp = '0, r, v, d0, d3;
  logic [31:0] rdat, pout, pdir;
  logic [3:0] done = '0, bt = '0, ow = '0, od = '0, brp, ssv, sdir, sto, fv;
  logic [3:0][4:0] pc = '0, btg = '0, ssf = '0, pcn, ssd;
  logic [3:0][2:0] ssc = '0;
  logic [3:0][3:0] txl = '0, rxl = '0;
  logic [3:0][31:0] odt = '0, om = '0, owd = '0;
  logic [3:0][15:0] fi;
  logic [5:0] se;
  int bad_count = 0, check_count = 0, cyc = 0, n;

  smec_exec_ctrl i_dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(a), .reg_wdata_i(wd),
    .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdat), .forced_instr_o(fi),
    .forced_valid_o(fv), .forced_done_i(done), .pc_i(pc), .branch_taken_i(bt),
    .branch_target_i(btg), .pc_next_o(pcn), .gpio_i(gp), .branch_pin_o(brp),
    .sideset_field_i(ssf), .sideset_bit_count_i(ssc), .sideset_valid_o(ssv),
    .sideset_data_o(ssd), .sideset_to_directions_o(sdir), .tx_level_i(txl),
    .rx_level_i(rxl), .status_ones_o(sto), .out_wr_i(ow), .out_dir_i(od),
    .out_data_i(odt), .out_mask_i(om), .out_word_i(owd), .pad_out_o(pout),
    .pad_dir_o(pdir));

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [8:0] ad, input logic [31:0] d);
    @(posedge clk);
    a <= ad; wd <= d; we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] ad, output logic [31:0] d);
    @(posedge clk);
    a <= ad; re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdat;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Side-set expectation: {valid, data}, count clamped to five
  function automatic logic [5:0] exp_sideset(input logic [4:0] f, input logic [2:0] c,
                                             input logic en);
    int k;
    logic [4:0] dat;
    k = (c > 3'h5) ? 5 : int'(c);
    dat = 5'h00;
    for (int j = 0; j < 5; j++) begin
      if (j < k - int'(en)) begin
        dat[j] = f[5 - k + j];
      end
    end
    return {(k != 0) && (!en || f[4]), dat};
  endfunction

  initial begin
    void'($urandom(62316));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(smec_pkg::SMEC_CTRL_OFS[i], r);
      `CHK(r, 32'h0001f000)
    end
    rd(9'h004, r);
    `CHK(r, 32'h0)
    // Fields against random settings
    for (int i = 0; i < 24; i++) begin
      n = i % 4;
      v = $urandom() | ((i < 4) ? 32'h40000000 : 32'h0);
      wr(smec_pkg::SMEC_CTRL_OFS[n], v);
      rd(smec_pkg::SMEC_CTRL_OFS[n], r);
      `CHK(r, v & 32'h7fffff9f)
      for (int b = 0; b < 3; b++) begin
        @(posedge clk);
        gp <= $urandom(); bt[n] <= (b == 1); btg[n] <= $urandom();
        pc[n] <= (b == 2) ? 5'(v[16:12] + 5'h01) : v[16:12];
        ssf[n] <= $urandom(); ssc[n] <= b ? 3'h5 : 3'($urandom());
        txl[n] <= $urandom(); rxl[n] <= $urandom();
        #1;
        se = exp_sideset(ssf[n], ssc[n], v[30]);
        `CHK(brp[n], gp[v[28:24]])
        if (b == 1) `CHK(pcn[n], btg[n])
        else `CHK(pcn[n], b ? 5'(pc[n] + 5'h01) : v[11:7])
        `CHK(sdir[n], v[29])
        `CHK(ssv[n], se[5])
        `CHK(ssd[n], se[4:0])
        `CHK(sto[n], (v[4] ? rxl[n] : txl[n]) < v[3:0])
      end
    end
    // Forced instruction held until done
    v = $urandom();
    wr(9'h0d8, v);
    #1;
    `CHK(fv[0], 1'b1)
    `CHK(fi[0], v[15:0])
    rd(9'h0cc, r);
    `CHK(r[31], 1'b1)
    @(posedge clk);
    done[0] <= 1'b1;
    @(posedge clk);
    done[0] <= 1'b0;
    #1;
    `CHK(fv[0], 1'b0)
    rd(9'h0cc, r);
    `CHK(r[31], 1'b0)
    // Pin priority and inline enable
    for (int i = 0; i < 4; i++) wr(smec_pkg::SMEC_CTRL_OFS[i], 32'h0001f000);
    d0 = $urandom();
    d3 = ~d0;
    @(posedge clk);
    odt[0] <= d0; odt[3] <= d3; om[0] <= '1; om[3] <= '1; ow <= 4'h9;
    @(posedge clk);
    ow <= 4'h0;
    #1;
    `CHK(pout, d3)
    wr(9'h114, 32'h002df000);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      owd[3] <= k ? 32'h20 : 32'h0; ow <= 4'h9;
      @(posedge clk);
      ow <= 4'h0;
      #1;
      `CHK(pout, k ? d3 : d0)
    end
    // Sticky re-drive of directions, then withdrawal by a gated write
    wr(9'h114, 32'h002ff000);
    @(posedge clk);
    od <= 4'h9; odt[3] <= d3; owd[3] <= 32'h20; ow <= 4'h8;
    @(posedge clk);
    ow <= 4'h1;
    @(posedge clk);
    ow <= 4'h0;
    #1;
    `CHK(pdir, d3)
    @(posedge clk);
    owd[3] <= 32'h0; ow <= 4'h9;
    @(posedge clk);
    ow <= 4'h0;
    #1;
    `CHK(pdir, d0)
    complete_run;
  end
endmodule
